//--- logic/pll_cfg_pkg.sv
// Constants, field layouts and state types of the PLL, divider and output configuration bank.
// Assumes one system clock; the serial control port pins are asynchronous to it.
package pll_cfg_pkg;

   // =========================================================
   // Register addresses (15-bit serial port address space)
   localparam logic [14:0] ADDR_REF_CLOCK_OUTPUT_CTRL = 15'h003C;
   localparam logic [14:0] ADDR_PLL_FEEDBACK_DIV_PV = 15'h003D;
   localparam logic [14:0] ADDR_PLL_FEEDBACK_DIV_N = 15'h003E;
   localparam logic [14:0] ADDR_PLL_OSCILLATOR_BIAS = 15'h003F;
   localparam logic [14:0] ADDR_LANE_PRE_EMPHASIS_CTRL = 15'h0048;
   localparam logic [14:0] ADDR_TRIGGER_OUTPUT_CTRL = 15'h0057;

   // =========================================================
   // Reset values
   localparam logic [7:0] RST_REF_CLOCK_OUTPUT_CTRL = 8'h01;
   localparam logic [7:0] RST_PLL_FEEDBACK_DIV_PV = 8'h00;
   localparam logic [7:0] RST_PLL_FEEDBACK_DIV_N = 8'h20;
   localparam logic [7:0] RST_PLL_OSCILLATOR_BIAS = 8'h4F;
   localparam logic [7:0] RST_LANE_PRE_EMPHASIS_CTRL = 8'h00;
   localparam logic [7:0] RST_TRIGGER_OUTPUT_CTRL = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // =========================================================
   // Field positions
   localparam int REF_OUT_EN_BIT = 0;
   localparam int V_DIV_LSB = 0;
   localparam int P_DIV_LSB = 2;
   localparam int N_DIV_LSB = 0;
   localparam int BIAS_LSB = 0;
   localparam int PE_LSB = 0;
   localparam int V_DIV_W = 2;
   localparam int P_DIV_W = 2;
   localparam int DIV_W = 6;
   localparam int BIAS_W = 7;
   localparam int PE_W = 4;

   // =========================================================
   // Divider codes and ratios
   localparam logic [1:0] DIV_CODE0 = 2'h0;
   localparam logic [1:0] DIV_CODE1 = 2'h1;
   localparam logic [1:0] DIV_CODE2 = 2'h2;
   localparam logic [5:0] V_RATIO0 = 6'h05;
   localparam logic [5:0] V_RATIO1 = 6'h04;
   localparam logic [5:0] V_RATIO2 = 6'h03;
   localparam logic [5:0] P_RATIO0 = 6'h01;
   localparam logic [5:0] P_RATIO1 = 6'h02;
   localparam logic [5:0] P_RATIO2 = 6'h04;
   localparam logic [5:0] RATIO_HOLD = 6'h00;

   // =========================================================
   // Serial frame: read flag, 15 address bits, 8 data bits
   localparam logic [3:0] CMD_LAST = 4'hF;
   localparam logic [3:0] DATA_LAST = 4'h7;
   localparam int CMD_RD_BIT = 15;

   typedef enum {SPI_CMD, SPI_WR, SPI_RD, SPI_DONE} spi_state_t;

   typedef struct packed {
      logic sclk_m;
      logic sclk_s;
      logic sclk_p;
      logic csn_m;
      logic csn_s;
      logic sdi_m;
      logic sdi_s;
      spi_state_t st;
      logic [3:0] cnt;
      logic [15:0] cmd;
      logic [7:0] wdat;
      logic [7:0] rdat;
      logic sdo;
      logic sdo_en;
      logic [7:0] ref_out;
      logic [7:0] div_pv;
      logic [7:0] div_n;
      logic [7:0] bias;
      logic [7:0] pre_emph;
      logic [7:0] trig;
   } cfg_state_t;

   typedef struct packed {
      logic [5:0] cnt;
      logic tick;
   } div_state_t;

endpackage

//--- logic/pll_divider_output_config_regs.sv
// PLL divider, oscillator bias, lane pre-emphasis and output control bank behind a serial control port.
// Assumes mode-0 serial port pins asynchronous to clk_sys_i, sclk well below a quarter of clk_sys_i,
// and an oscillator tick strobe on clk_sys_i standing in for the analog oscillator.
`timescale 1ns/1ps
module pll_divider_output_config_regs #(
   parameter int LANES = 8
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic spi_sclk_i,
   input wire logic spi_csn_i,
   input wire logic spi_sdi_i,
   output logic spi_sdo_o,
   output logic spi_sdo_oe_n_o,
   input wire logic sampling_pll_reset_i,
   input wire logic osc_tick_i,
   output logic ref_clock_output_enable_o,
   output logic [1:0] first_div_code_o,
   output logic [1:0] second_div_code_o,
   output logic [5:0] third_div_value_o,
   output logic [6:0] oscillator_bias_level_o,
   output logic [LANES*4-1:0] lane_pre_emphasis_level_o,
   output logic [7:0] trigger_output_ctrl_o,
   output logic sampling_clk_tick_o,
   output logic feedback_clk_tick_o
);

   // =========================================================
   // Elaboration checks
   if (LANES < 1 || LANES > 8) begin : g_lanes_check
      $error("LANES must be 1 to 8");
   end

   // =========================================================
   // Functions
   function automatic logic [5:0] first_ratio(input logic [1:0] code);
      case (code)
         pll_cfg_pkg::DIV_CODE0: first_ratio = pll_cfg_pkg::V_RATIO0;
         pll_cfg_pkg::DIV_CODE1: first_ratio = pll_cfg_pkg::V_RATIO1;
         pll_cfg_pkg::DIV_CODE2: first_ratio = pll_cfg_pkg::V_RATIO2;
         default: first_ratio = pll_cfg_pkg::RATIO_HOLD;
      endcase
   endfunction

   function automatic logic [5:0] second_ratio(input logic [1:0] code);
      case (code)
         pll_cfg_pkg::DIV_CODE0: second_ratio = pll_cfg_pkg::P_RATIO0;
         pll_cfg_pkg::DIV_CODE1: second_ratio = pll_cfg_pkg::P_RATIO1;
         pll_cfg_pkg::DIV_CODE2: second_ratio = pll_cfg_pkg::P_RATIO2;
         default: second_ratio = pll_cfg_pkg::RATIO_HOLD;
      endcase
   endfunction

   function automatic logic [7:0] read_reg(input logic [14:0] addr, input pll_cfg_pkg::cfg_state_t s);
      case (addr)
         pll_cfg_pkg::ADDR_REF_CLOCK_OUTPUT_CTRL: read_reg = s.ref_out;
         pll_cfg_pkg::ADDR_PLL_FEEDBACK_DIV_PV: read_reg = s.div_pv;
         pll_cfg_pkg::ADDR_PLL_FEEDBACK_DIV_N: read_reg = s.div_n;
         pll_cfg_pkg::ADDR_PLL_OSCILLATOR_BIAS: read_reg = s.bias;
         pll_cfg_pkg::ADDR_LANE_PRE_EMPHASIS_CTRL: read_reg = s.pre_emph;
         pll_cfg_pkg::ADDR_TRIGGER_OUTPUT_CTRL: read_reg = s.trig;
         default: read_reg = pll_cfg_pkg::RD_UNMAPPED;
      endcase
   endfunction

   // =========================================================
   // State
   pll_cfg_pkg::cfg_state_t q, d;
   logic rise;
   logic fall;
   logic [7:0] wbyte;
   logic [14:0] rd_addr;

   assign rise = q.sclk_s & ~q.sclk_p;
   assign fall = ~q.sclk_s & q.sclk_p;
   assign wbyte = {q.wdat[6:0], q.sdi_s};
   assign rd_addr = {q.cmd[13:0], q.sdi_s};

   // =========================================================
   // Serial port and register file
   always_comb begin
      d = q;
      // Two flops on every serial port pin before any logic looks at it
      d.sclk_m = spi_sclk_i;
      d.sclk_s = q.sclk_m;
      d.sclk_p = q.sclk_s;
      d.csn_m = spi_csn_i;
      d.csn_s = q.csn_m;
      d.sdi_m = spi_sdi_i;
      d.sdi_s = q.sdi_m;
      if (q.csn_s) begin
         // Deselect aborts a frame; a partial write is dropped
         d.st = pll_cfg_pkg::SPI_CMD;
         d.cnt = 4'h0;
         d.sdo_en = 1'b0;
         d.sdo = 1'b0;
      end else begin
         case (q.st)
            pll_cfg_pkg::SPI_CMD: begin
               if (rise) begin
                  d.cmd = {q.cmd[14:0], q.sdi_s};
                  d.cnt = q.cnt + 4'h1;
                  if (q.cnt == pll_cfg_pkg::CMD_LAST) begin
                     d.cnt = 4'h0;
                     if (q.cmd[pll_cfg_pkg::CMD_RD_BIT - 1]) begin
                        d.rdat = read_reg(rd_addr, q);
                        d.st = pll_cfg_pkg::SPI_RD;
                     end else begin
                        d.st = pll_cfg_pkg::SPI_WR;
                     end
                  end
               end
            end
            pll_cfg_pkg::SPI_WR: begin
               if (rise) begin
                  d.wdat = wbyte;
                  d.cnt = q.cnt + 4'h1;
                  if (q.cnt == pll_cfg_pkg::DATA_LAST) begin
                     d.st = pll_cfg_pkg::SPI_DONE;
                     // Whole byte stored, reserved bits included; software keeps them at reset value
                     case (q.cmd[14:0])
                        pll_cfg_pkg::ADDR_REF_CLOCK_OUTPUT_CTRL: d.ref_out = wbyte;
                        pll_cfg_pkg::ADDR_PLL_FEEDBACK_DIV_PV: d.div_pv = wbyte;
                        pll_cfg_pkg::ADDR_PLL_FEEDBACK_DIV_N: d.div_n = wbyte;
                        pll_cfg_pkg::ADDR_PLL_OSCILLATOR_BIAS: d.bias = wbyte;
                        pll_cfg_pkg::ADDR_LANE_PRE_EMPHASIS_CTRL: d.pre_emph = wbyte;
                        pll_cfg_pkg::ADDR_TRIGGER_OUTPUT_CTRL: d.trig = wbyte;
                        default: d.wdat = wbyte;
                     endcase
                  end
               end
            end
            pll_cfg_pkg::SPI_RD: begin
               if (fall) begin
                  d.sdo = q.rdat[7];
                  d.rdat = {q.rdat[6:0], 1'b0};
                  d.sdo_en = 1'b1;
               end
               if (rise) begin
                  d.cnt = q.cnt + 4'h1;
                  if (q.cnt == pll_cfg_pkg::DATA_LAST) begin
                     d.st = pll_cfg_pkg::SPI_DONE;
                  end
               end
            end
            pll_cfg_pkg::SPI_DONE: begin
               // Extra clocks are ignored; the line is released after the last bit
               if (fall) begin
                  d.sdo_en = 1'b0;
                  d.sdo = 1'b0;
               end
            end
            default: begin
               d.st = pll_cfg_pkg::SPI_CMD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         q <= '0;
         q.st <= pll_cfg_pkg::SPI_CMD;
         q.csn_m <= 1'b1;
         q.csn_s <= 1'b1;
         q.ref_out <= pll_cfg_pkg::RST_REF_CLOCK_OUTPUT_CTRL;
         q.div_pv <= pll_cfg_pkg::RST_PLL_FEEDBACK_DIV_PV;
         q.div_n <= pll_cfg_pkg::RST_PLL_FEEDBACK_DIV_N;
         q.bias <= pll_cfg_pkg::RST_PLL_OSCILLATOR_BIAS;
         q.pre_emph <= pll_cfg_pkg::RST_LANE_PRE_EMPHASIS_CTRL;
         q.trig <= pll_cfg_pkg::RST_TRIGGER_OUTPUT_CTRL;
      end else begin
         q <= d;
      end
   end

   // =========================================================
   // Configuration outputs
   assign spi_sdo_o = q.sdo;
   assign spi_sdo_oe_n_o = ~q.sdo_en;
   assign ref_clock_output_enable_o = q.ref_out[pll_cfg_pkg::REF_OUT_EN_BIT];
   assign first_div_code_o = q.div_pv[pll_cfg_pkg::V_DIV_LSB +: pll_cfg_pkg::V_DIV_W];
   assign second_div_code_o = q.div_pv[pll_cfg_pkg::P_DIV_LSB +: pll_cfg_pkg::P_DIV_W];
   assign third_div_value_o = q.div_n[pll_cfg_pkg::N_DIV_LSB +: pll_cfg_pkg::DIV_W];
   assign oscillator_bias_level_o = q.bias[pll_cfg_pkg::BIAS_LSB +: pll_cfg_pkg::BIAS_W];
   assign trigger_output_ctrl_o = q.trig;

   // Single shared level; per-lane setting is not possible
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         lane_pre_emphasis_level_o[i*4 +: 4] = q.pre_emph[pll_cfg_pkg::PE_LSB +: pll_cfg_pkg::PE_W];
      end
   end

   // =========================================================
   // Feedback divider chain
   // Dividers are parked while the PLL reset is held, so ratio changes start clean
   logic first_tick;

   tick_divider u_first_div (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .hold_i(sampling_pll_reset_i),
      .ratio_i(first_ratio(first_div_code_o)),
      .tick_i(osc_tick_i),
      .tick_o(first_tick)
   );

   tick_divider u_second_div (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .hold_i(sampling_pll_reset_i),
      .ratio_i(second_ratio(second_div_code_o)),
      .tick_i(first_tick),
      .tick_o(sampling_clk_tick_o)
   );

   tick_divider u_third_div (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .hold_i(sampling_pll_reset_i),
      .ratio_i(third_div_value_o),
      .tick_i(sampling_clk_tick_o),
      .tick_o(feedback_clk_tick_o)
   );

endmodule

//--- logic/tick_divider.sv
// Programmable tick divider: one output tick per ratio input ticks.
// Assumes tick_i and hold_i come from logic on clk_sys_i.
`timescale 1ns/1ps
module tick_divider (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic hold_i,
   input wire logic [5:0] ratio_i,
   input wire logic tick_i,
   output logic tick_o
);

   // =========================================================
   // State
   pll_cfg_pkg::div_state_t q, d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      // Ratio of zero parks the divider; reserved codes map here
      if (hold_i || ratio_i == pll_cfg_pkg::RATIO_HOLD) begin
         d.cnt = 6'h00;
      end else if (tick_i) begin
         if (q.cnt >= ratio_i - 6'h01) begin
            d.cnt = 6'h00;
            d.tick = 1'b1;
         end else begin
            d.cnt = q.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick_o = q.tick;

endmodule

//--- verif/pll_divider_output_config_regs_props.sv
// Concurrent checks on the PLL divider and output configuration bank.
// Assumes it is bound to the bank's top module and sees only its ports.
`timescale 1ns/1ps
module pll_cfg_props #(
   parameter int LANES = 8
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic sampling_pll_reset_i,
   input wire logic osc_tick_i,
   input wire logic ref_clock_output_enable_o,
   input wire logic [5:0] third_div_value_o,
   input wire logic [LANES*4-1:0] lane_pre_emphasis_level_o,
   input wire logic [7:0] trigger_output_ctrl_o,
   input wire logic sampling_clk_tick_o,
   input wire logic feedback_clk_tick_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   // =========================================
   // Assertions
   chk_ref_en_reset: assert property ($rose(resetn_i) |-> ref_clock_output_enable_o)
      else $error("ref output enable clear after reset");
   chk_trig_reset: assert property ($rose(resetn_i) |-> trigger_output_ctrl_o == 8'h00)
      else $error("trigger control not zero after reset");
   chk_third_reset: assert property ($rose(resetn_i) |-> third_div_value_o == 6'h20)
      else $error("third divider not 32 after reset");
   chk_lanes_common: assert property (lane_pre_emphasis_level_o == {LANES{lane_pre_emphasis_level_o[3:0]}})
      else $error("lane pre-emphasis levels differ");
   chk_samp_origin: assert property (sampling_clk_tick_o |-> $past(osc_tick_i, 2))
      else $error("sampling tick without oscillator tick");
   chk_fb_origin: assert property (feedback_clk_tick_o |-> $past(sampling_clk_tick_o))
      else $error("feedback tick without sampling tick");
   // Hold clears the tick of all three divider stages one clock later; five held cycles cover that
   chk_pll_hold: assert property (sampling_pll_reset_i [*5] |-> !sampling_clk_tick_o && !feedback_clk_tick_o)
      else $error("divider tick while PLL reset held");
   chk_unit_pass: assert property ((third_div_value_o == 6'h01) [*2] ##0
      (sampling_clk_tick_o && !sampling_pll_reset_i) |=> feedback_clk_tick_o)
      else $error("third divider by one dropped a tick");
   cov_samp: cover property (sampling_clk_tick_o);
   cov_fb: cover property (feedback_clk_tick_o);
   cov_ref_off: cover property (!ref_clock_output_enable_o);
endmodule
bind pll_divider_output_config_regs pll_cfg_props #(.LANES(LANES)) u_props (
   .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sampling_pll_reset_i(sampling_pll_reset_i),
   .osc_tick_i(osc_tick_i), .ref_clock_output_enable_o(ref_clock_output_enable_o),
   .third_div_value_o(third_div_value_o), .lane_pre_emphasis_level_o(lane_pre_emphasis_level_o),
   .trigger_output_ctrl_o(trigger_output_ctrl_o), .sampling_clk_tick_o(sampling_clk_tick_o),
   .feedback_clk_tick_o(feedback_clk_tick_o));

//--- verif/tb_pll_divider_output_config_regs.sv
// Self-checking bench for the PLL divider and output configuration bank.
// Assumes the bank's 24-bit mode-0 serial frame and one clock of latency per divider stage.
`timescale 1ns/1ps
module tb_pll_divider_output_config_regs;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic sclk = 1'b0;
   logic csn = 1'b1;
   logic sdi = 1'b0;
   logic pll_rst = 1'b1;
   logic osc = 1'b0;
   logic osc_en = 1'b0;
   logic sdo, oe_n, ref_en, samp, fb;
   logic [1:0] v_code, p_code;
   logic [5:0] n_val;
   logic [6:0] bias;
   logic [31:0] lanes;
   logic [7:0] trig, rd;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   int osc_cnt = 0;
   int samp_cnt = 0;
   int fb_cnt = 0;
   int v, p, vr, pr, nv;
   logic [14:0] addr_t [6] = '{15'h003C, 15'h003D, 15'h003E, 15'h003F, 15'h0048, 15'h0057};
   logic [7:0] rst_t [6] = '{8'h01, 8'h00, 8'h20, 8'h4F, 8'h00, 8'h00};
   logic [7:0] wr_t [6] = '{8'h00, 8'h06, 8'h05, 8'h4A, 8'h09, 8'h83};
   pll_divider_output_config_regs DUT (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi_sclk_i(sclk), .spi_csn_i(csn),
      .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_n_o(oe_n), .sampling_pll_reset_i(pll_rst),
      .osc_tick_i(osc), .ref_clock_output_enable_o(ref_en), .first_div_code_o(v_code),
      .second_div_code_o(p_code), .third_div_value_o(n_val), .oscillator_bias_level_o(bias),
      .lane_pre_emphasis_level_o(lanes), .trigger_output_ctrl_o(trig), .sampling_clk_tick_o(samp),
      .feedback_clk_tick_o(fb));
   // =========================================
   // Clock, oscillator ticks, counters
   always #4 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) osc <= osc_en ? ~osc : 1'b0;
   // Counted on the falling edge, where registered pulses are settled
   always @(negedge clk_sys_i) begin
      if (osc && !pll_rst) osc_cnt++;
      if (samp === 1'b1) samp_cnt++;
      if (fb === 1'b1) fb_cnt++;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         wrap_up();
      end
   end
   // =========================================
   // Tasks
   task automatic wrap_up;
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Half periods of five clocks keep every serial edge visible through the sync flops
   task automatic spi(input logic rdn, input logic [14:0] addr, input logic [7:0] wd, output logic [7:0] rdv);
      logic [23:0] fr;
      fr = {rdn, addr, wd};
      rdv = 8'h00;
      csn <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi <= fr[i];
         repeat (5) @(posedge clk_sys_i);
         if (i < 8) begin
            rdv[i] = sdo;
            `CHK("sdo_oe_n", ~rdn, oe_n)
         end
         sclk <= 1'b1;
         repeat (5) @(posedge clk_sys_i);
         sclk <= 1'b0;
      end
      repeat (6) @(posedge clk_sys_i);
      csn <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      `CHK("sdo_oe_n idle", 1'b1, oe_n)
      `CHK("sdo idle", 1'b0, sdo)
   endtask
   task automatic do_reset;
      resetn_i <= 1'b0;
      repeat (20) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      `CHK("ref_en", 1'b1, ref_en)
      `CHK("trig", 8'h00, trig)
      `CHK("n_val", 6'h20, n_val)
   endtask
   // =========================================
   // Main sequence
   initial begin
      do_reset();
      for (int i = 0; i < 6; i++) begin
         spi(1'b1, addr_t[i], 8'h00, rd);
         `CHK("reset read", rst_t[i], rd)
      end
      for (int i = 0; i < 6; i++) spi(1'b0, addr_t[i], wr_t[i], rd);
      for (int i = 0; i < 6; i++) begin
         spi(1'b1, addr_t[i], 8'h00, rd);
         `CHK("readback", wr_t[i], rd)
      end
      `CHK("ref_en", 1'b0, ref_en)
      `CHK("bias", 7'h4A, bias)
      `CHK("lanes", {8{4'h9}}, lanes)
      `CHK("trig", 8'h83, trig)
      `CHK("n_val", 6'h05, n_val)
      spi(1'b0, 15'h0040, 8'hFF, rd);
      spi(1'b1, 15'h0040, 8'h00, rd);
      `CHK("unmapped", 8'h00, rd)
      for (int c = 0; c < 9; c++) begin
         v = c % 3;
         p = c / 3;
         vr = 5 - v;
         pr = 1 << p;
         nv = v + 1;
         pll_rst <= 1'b1;
         osc_en <= 1'b1;
         spi(1'b0, 15'h003D, {4'h0, p[1:0], v[1:0]}, rd);
         spi(1'b0, 15'h003E, {2'h0, nv[5:0]}, rd);
         `CHK("v_code", v[1:0], v_code)
         `CHK("p_code", p[1:0], p_code)
         `CHK("n_val", nv[5:0], n_val)
         osc_cnt = 0;
         samp_cnt = 0;
         fb_cnt = 0;
         pll_rst <= 1'b0;
         repeat (480) @(posedge clk_sys_i);
         osc_en <= 1'b0;
         repeat (8) @(posedge clk_sys_i);
         `CHK("samp ticks", osc_cnt / (vr * pr), samp_cnt)
         `CHK("fb ticks", osc_cnt / (vr * pr) / nv, fb_cnt)
      end
      do_reset();
      wrap_up();
   end
endmodule
